/* File: verilog/telegraph_distortion_counter.sv */
`timescale 1ns/100ps
`default_nettype none

// How it works
// - each line falling edge steps noise counter, down when early, up when late
// - down step landing on 4 removes a pulse, up step landing on 3 adds one
// - start-stop mode gates centi-bit clock off in stop, reopens at start edge
// - bit timing is the centi-bit clock divided by one hundred
// - transition counter stepped by bit timing drives ten active-low lines
// - five-level code: rise of line six clears start-detect flag before start
// - first edge spike with flag clear gives start reset and sets flag
// - stop transfer goes low when gate closes, high when line zero rises
// - centi-bit steps advance two decades 0..99, units wrap steps the tens
// - decades count in 1-2-4-2 code, four jumps to 1011
// - complemented decades count down from 99 while true outputs count up
// - bit timing low for counts 0..49, high for counts 50..99
// - up-count or down-count presented by bit timing, folding around zero
// - transfer pulse loads presented count into register, held until next
// - stored count is percent displacement early or late, 0 to 49
// - add-one flag marks downcount half readings, one short
// - centi-bit clock is the 200x timebase divided by two
// - subtract drops one timebase pulse, add also injects one centi-bit pulse
module telegraph_distortion_counter
	import telegraph_distortion_pkg::*;
(
	input  wire logic                   ref_clk,
	input  wire logic                   rst_n,
	input  wire logic                   lineSignal,
	input  wire logic                   timebase200,
	input  wire logic                   transferPulse,
	input  wire logic                   startStopMode,
	input  wire logic                   fiveLevelCode,
	output logic                        centiBitClock,
	output logic                        bitTiming,
	output logic [TRANS_LINES-1:0]      transitionLines_n,
	output logic                        lineEdgeSpike,
	output logic                        startResetPulse,
	output logic                        stopTransfer,
	output logic [3:0]                  distTens,
	output logic [3:0]                  distUnits,
	output logic                        addOneFlag
);

	// two-stage synchronisers for every pin
	logic [PIN_COUNT-1:0] pinMeta_q;
	logic [PIN_COUNT-1:0] pinSync_q;
	logic [PIN_COUNT-1:0] pinLast_q;
	logic [PIN_COUNT-1:0] pinRaw;

	assign pinRaw = {fiveLevelCode, startStopMode, transferPulse, timebase200, lineSignal};

	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi++)
		begin : g_sync
			always_ff @(posedge ref_clk)
			begin
				if (!rst_n)
				begin
					pinMeta_q[gi] <= 1'b0;
					pinSync_q[gi] <= 1'b0;
					pinLast_q[gi] <= 1'b0;
				end
				else
				begin
					pinMeta_q[gi] <= pinRaw[gi];
					pinSync_q[gi] <= pinMeta_q[gi];
					pinLast_q[gi] <= pinSync_q[gi];
				end
			end
		end
	endgenerate

	logic lineFall;
	logic tbFall;
	logic xfrRise;
	logic ssMode;
	logic fiveLevel;

	assign lineFall  = pinLast_q[PIN_LINE] & ~pinSync_q[PIN_LINE];
	assign tbFall    = pinLast_q[PIN_TB200] & ~pinSync_q[PIN_TB200];
	assign xfrRise   = ~pinLast_q[PIN_XFR] & pinSync_q[PIN_XFR];
	assign ssMode    = pinSync_q[PIN_SSMODE];
	assign fiveLevel = pinSync_q[PIN_FIVE];

	// decade counter state, driven by the instances below
	logic [3:0] unitsCode;
	logic [3:0] tensCode;
	logic       unitsWrap;
	logic       early;

	assign early = tensCode[3];

	// noise-rejection counter and correction requests
	logic [2:0] noiseCnt_q;
	logic [2:0] noiseCnt_d;
	logic [2:0] noiseStepped;
	logic       subReq;
	logic       addReq;

	assign noiseStepped = early ? 3'(noiseCnt_q - 3'h1) : 3'(noiseCnt_q + 3'h1);
	assign subReq = lineFall & early & (noiseStepped == NOISE_SUB_AT);
	assign addReq = lineFall & ~early & (noiseStepped == NOISE_ADD_AT);
	assign noiseCnt_d = subReq ? NOISE_REST_DN
		: addReq ? NOISE_REST_UP
		: lineFall ? noiseStepped
		: noiseCnt_q;

	// divide-by-two with pulse removal and injection
	logic div2_q;
	logic div2_d;
	logic suppressPend_q;
	logic suppressPend_d;
	logic injectPend_q;
	logic injectPend_d;
	logic dividerTick;
	logic injectNow;
	logic centiTick;
	logic suppressNow;

	assign suppressNow = tbFall & suppressPend_q;
	assign div2_d      = (tbFall & ~suppressPend_q) ? ~div2_q : div2_q;
	assign dividerTick = tbFall & ~suppressPend_q & div2_q;
	assign injectNow   = tbFall & ~suppressPend_q & injectPend_q & ~div2_q;
	assign centiTick   = dividerTick | injectNow;
	// a new request wins over the consuming edge
	assign suppressPend_d = (subReq | addReq) | (suppressPend_q & ~suppressNow);
	assign injectPend_d   = addReq | (injectPend_q & ~injectNow);

	// start-stop framing
	logic startDetect_q;
	logic startDetect_d;
	logic startReset;
	logic gateOpen;
	logic centiStep;
	logic selRise;
	logic lineZeroRise;
	logic stopXfer_q;
	logic stopXfer_d;

	assign startReset = ssMode & lineFall & ~startDetect_q;
	assign gateOpen   = ~ssMode | startDetect_q;
	assign centiStep  = centiTick & gateOpen;
	assign startDetect_d = startReset ? 1'b1
		: (ssMode & selRise) ? 1'b0
		: startDetect_q;
	assign stopXfer_d = (ssMode & selRise) ? 1'b0
		: lineZeroRise ? 1'b1
		: stopXfer_q;

	// distortion counter: units stepped by centi-bit steps, tens by units wrap
	weighted_decade u_units (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.step    (centiStep),
		.clear   (startReset),
		.code    (unitsCode),
		.wrap    (unitsWrap)
	);

	weighted_decade u_tens (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.step    (unitsWrap),
		.clear   (startReset),
		.code    (tensCode),
		.wrap    ()
	);

	// bit timing rises at weighted fifty in the tens decade
	logic bitTimingLast_q;
	logic btRise;

	assign btRise = early & ~bitTimingLast_q;

	// transition counter and its active-low lines
	logic [3:0]             transCnt_q;
	logic [3:0]             transCnt_d;
	logic [TRANS_LINES-1:0] transLines_q;
	logic [TRANS_LINES-1:0] transLines_d;

	assign transCnt_d = startReset ? TRANS_RESET
		: !btRise ? transCnt_q
		: (transCnt_q == TRANS_LAST) ? TRANS_RESET
		: 4'(transCnt_q + 4'h1);

	generate
		for (gi = 0; gi < TRANS_LINES; gi++)
		begin : g_lines
			assign transLines_d[gi] = (transCnt_d != 4'(gi));
		end
	endgenerate

	logic selLine;
	logic selLineLast_q;
	logic lineZeroLast_q;

	assign selLine      = fiveLevel ? transLines_q[STOP_LINE_5] : transLines_q[STOP_LINE_8];
	assign selRise      = selLine & ~selLineLast_q;
	assign lineZeroRise = transLines_q[START_LINE] & ~lineZeroLast_q;

	// presented count: up-count in late half, complement in early half
	logic [3:0] presTens;
	logic [3:0] presUnits;

	assign presTens  = early ? ~tensCode : tensCode;
	assign presUnits = early ? ~unitsCode : unitsCode;

	// distortion register
	logic [3:0] storedTens_q;
	logic [3:0] storedUnits_q;
	logic       addOne_q;
	logic       centiOut_q;
	logic       spike_q;
	logic       startPulse_q;

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			noiseCnt_q     <= NOISE_RESET;
			div2_q         <= 1'b0;
			suppressPend_q <= 1'b0;
			injectPend_q   <= 1'b0;
			startDetect_q  <= 1'b0;
			stopXfer_q     <= 1'b0;
		end
		else
		begin
			noiseCnt_q     <= noiseCnt_d;
			div2_q         <= div2_d;
			suppressPend_q <= suppressPend_d;
			injectPend_q   <= injectPend_d;
			startDetect_q  <= startDetect_d;
			stopXfer_q     <= stopXfer_d;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			transCnt_q      <= TRANS_RESET;
			transLines_q    <= {TRANS_LINES{1'b1}};
			bitTimingLast_q <= 1'b0;
			selLineLast_q   <= 1'b1;
			lineZeroLast_q  <= 1'b1;
		end
		else
		begin
			transCnt_q      <= transCnt_d;
			transLines_q    <= transLines_d;
			bitTimingLast_q <= early;
			selLineLast_q   <= selLine;
			lineZeroLast_q  <= transLines_q[START_LINE];
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			storedTens_q  <= CODE_ZERO;
			storedUnits_q <= CODE_ZERO;
			addOne_q      <= 1'b0;
		end
		else if (xfrRise)
		begin
			storedTens_q  <= presTens;
			storedUnits_q <= presUnits;
			addOne_q      <= early;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			centiOut_q   <= 1'b0;
			spike_q      <= 1'b0;
			startPulse_q <= 1'b0;
		end
		else
		begin
			centiOut_q   <= div2_q & gateOpen;
			spike_q      <= lineFall;
			startPulse_q <= startReset;
		end
	end

	assign centiBitClock     = centiOut_q;
	assign bitTiming         = early;
	assign transitionLines_n = transLines_q;
	assign lineEdgeSpike     = spike_q;
	assign startResetPulse   = startPulse_q;
	assign stopTransfer      = stopXfer_q;
	assign distTens          = storedTens_q;
	assign distUnits         = storedUnits_q;
	assign addOneFlag        = addOne_q;

	a_noise_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
		lineFall && early && !subReq |=> noiseCnt_q == 3'($past(noiseCnt_q) - 3'h1))
		else $error("noise counter did not step down on early edge");

	a_sub_trigger: assert property (@(posedge ref_clk) disable iff (!rst_n)
		subReq |=> suppressPend_q && noiseCnt_q == NOISE_REST_DN)
		else $error("subtract request not latched");

	a_add_inject: assert property (@(posedge ref_clk) disable iff (!rst_n)
		addReq |=> injectPend_q && suppressPend_q)
		else $error("add request did not arm pulse injection");

	a_gate_closed: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ssMode && !startDetect_q && !startReset |=> $stable(unitsCode))
		else $error("distortion counter moved while gate closed");

	a_half_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
		bitTiming == (weightedValue(tensCode) >= VALUE_FIVE))
		else $error("bit timing level does not match count half");

	a_units_wrap: assert property (@(posedge ref_clk) disable iff (!rst_n)
		centiStep && !startReset && unitsCode == CODE_NINE
		|=> unitsCode == CODE_ZERO && tensCode != $past(tensCode))
		else $error("units wrap did not advance tens");

	a_code_legal: assert property (@(posedge ref_clk) disable iff (!rst_n)
		weightedValue(unitsCode) <= VALUE_NINE && weightedValue(tensCode) <= VALUE_NINE
		&& (unitsCode[3] || unitsCode <= CODE_FOUR))
		else $error("decade left weighted code");

	a_complement: assert property (@(posedge ref_clk) disable iff (!rst_n)
		weightedValue(~unitsCode) == 4'(VALUE_NINE - weightedValue(unitsCode)))
		else $error("complemented decade is not nines complement");

	a_spike_block: assert property (@(posedge ref_clk) disable iff (!rst_n)
		startReset |=> startDetect_q ##1 !startResetPulse)
		else $error("second start reset passed while flag set");

	a_stop_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ssMode && selRise |=> !stopTransfer)
		else $error("stop transfer not low after gate closed");

	a_xfr_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
		xfrRise |=> distTens == $past(presTens) && distUnits == $past(presUnits)
		&& addOneFlag == $past(early))
		else $error("transfer did not load presented count");

endmodule

`default_nettype wire

/* File: common/telegraph_distortion_pkg.sv */
package telegraph_distortion_pkg;

	// input synchroniser depth
	localparam int SYNC_STAGES = 2;

	// noise-rejection counter
	localparam int        NOISE_W         = 3;
	localparam logic [2:0] NOISE_SUB_AT   = 3'h4;
	localparam logic [2:0] NOISE_ADD_AT   = 3'h3;
	localparam logic [2:0] NOISE_REST_DN  = 3'h7;
	localparam logic [2:0] NOISE_REST_UP  = 3'h0;
	localparam logic [2:0] NOISE_RESET    = 3'h0;

	// 1-2-4-2 weighted decade codes
	localparam logic [3:0] CODE_ZERO = 4'h0;
	localparam logic [3:0] CODE_FOUR = 4'h4;
	localparam logic [3:0] CODE_FIVE = 4'hb;
	localparam logic [3:0] CODE_NINE = 4'hf;
	localparam logic [3:0] CODE_SKEW = 4'h6;
	localparam logic [3:0] VALUE_FIVE = 4'h5;
	localparam logic [3:0] VALUE_NINE = 4'h9;

	// centi-bit steps per bit, as two decades
	localparam int CENTI_PER_BIT = 100;

	// transition counter
	localparam int         TRANS_LINES   = 10;
	localparam logic [3:0] TRANS_LAST    = 4'h9;
	localparam logic [3:0] TRANS_RESET   = 4'h0;
	localparam int         STOP_LINE_5   = 6;
	localparam int         STOP_LINE_8   = 9;
	localparam int         START_LINE    = 0;

	// pin bundle positions in the synchroniser
	localparam int PIN_LINE   = 0;
	localparam int PIN_TB200  = 1;
	localparam int PIN_XFR    = 2;
	localparam int PIN_SSMODE = 3;
	localparam int PIN_FIVE   = 4;
	localparam int PIN_COUNT  = 5;

	// decimal value of a weighted code
	function automatic logic [3:0] weightedValue(input logic [3:0] code);
		weightedValue = code[3] ? 4'(code - CODE_SKEW) : code;
	endfunction

endpackage

/* File: verilog/weighted_decade.sv */
`timescale 1ns/100ps
`default_nettype none

module weighted_decade
	import telegraph_distortion_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       step,
	input  wire logic       clear,
	output logic [3:0]      code,
	output logic            wrap
);

	logic [3:0] code_q;
	logic [3:0] code_d;
	logic [3:0] codeInc;

	// four jumps to weighted five, nine returns to zero
	assign codeInc = (code_q == CODE_FOUR) ? CODE_FIVE
		: (code_q == CODE_NINE) ? CODE_ZERO
		: 4'(code_q + 4'h1);
	assign code_d = clear ? CODE_ZERO : step ? codeInc : code_q;
	assign wrap   = step & ~clear & (code_q == CODE_NINE);
	assign code   = code_q;

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			code_q <= CODE_ZERO;
		else
			code_q <= code_d;
	end

endmodule

`default_nettype wire

/* File: test/line_source_model.sv */
`timescale 1ns/100ps
`default_nettype none

module line_source_model
(
	input  wire logic ref_clk,
	output logic      timebase200,
	output logic      lineSignal
);
	logic [1:0] phase_q = 2'h0;
	logic       level_q = 1'b1;

	// free-running 200x timebase, each level held two cycles
	always @(posedge ref_clk)
		phase_q <= phase_q + 2'h1;

	assign timebase200 = phase_q[1];
	assign lineSignal  = level_q;

	// one mark-to-space transition, back to mark after lowCycles
	task automatic lineFall(input int lowCycles);
		level_q <= 1'b0;
		repeat (lowCycles) @(posedge ref_clk);
		level_q <= 1'b1;
	endtask
endmodule

`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_top
	import telegraph_distortion_pkg::*;
;
	logic                   ref_clk       = 1'b0;
	logic                   rst_n         = 1'b0;
	logic                   transferPulse = 1'b0;
	logic                   startStopMode = 1'b0;
	logic                   fiveLevelCode = 1'b1;
	wire logic              lineSignal;
	wire logic              timebase200;
	logic                   centiBitClock;
	logic                   bitTiming;
	logic [TRANS_LINES-1:0] transitionLines_n;
	logic                   lineEdgeSpike;
	logic                   startResetPulse;
	logic                   stopTransfer;
	logic [3:0]             distTens;
	logic [3:0]             distUnits;
	logic                   addOneFlag;
	logic                   clkPrev_q     = 1'b0;
	int                     mismatches    = 0;
	int                     n_compared    = 0;
	int                     cyc           = 0;
	int                     centiFalls    = 0;
	int                     spikes        = 0;
	int                     starts        = 0;

	telegraph_distortion_counter telegraph_distortion_counter_inst (
		.ref_clk           (ref_clk),
		.rst_n             (rst_n),
		.lineSignal        (lineSignal),
		.timebase200       (timebase200),
		.transferPulse     (transferPulse),
		.startStopMode     (startStopMode),
		.fiveLevelCode     (fiveLevelCode),
		.centiBitClock     (centiBitClock),
		.bitTiming         (bitTiming),
		.transitionLines_n (transitionLines_n),
		.lineEdgeSpike     (lineEdgeSpike),
		.startResetPulse   (startResetPulse),
		.stopTransfer      (stopTransfer),
		.distTens          (distTens),
		.distUnits         (distUnits),
		.addOneFlag        (addOneFlag)
	);

	line_source_model line_source_model_inst (
		.ref_clk     (ref_clk),
		.timebase200 (timebase200),
		.lineSignal  (lineSignal)
	);

	initial
	begin
		forever #2 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		cyc <= cyc + 1;
		clkPrev_q <= centiBitClock;
		if (clkPrev_q === 1'b1 && centiBitClock === 1'b0)
			centiFalls <= centiFalls + 1;
		if (lineEdgeSpike === 1'b1)
			spikes <= spikes + 1;
		if (startResetPulse === 1'b1)
			starts <= starts + 1;
	end

	function automatic logic [3:0] enc(input int d);
		return (d < 5) ? 4'(d) : 4'(d + 6);
	endfunction

	task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
		n_compared++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic print_verdict();
		if (mismatches == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic doReset();
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
	endtask

	task automatic waitBt(input logic lvl);
		logic prev;
		prev = bitTiming;
		repeat (2000)
		begin
			@(posedge ref_clk);
			if (prev === ~lvl && bitTiming === lvl)
				return;
			prev = bitTiming;
		end
		cmp(16'h0, 16'h1, "bit timing stalled");
	endtask

	task automatic waitCenti(input int n);
		logic prev;
		int   seen;
		prev = centiBitClock;
		seen = 0;
		repeat (n * 10 + 20)
		begin
			@(posedge ref_clk);
			if (prev === 1'b1 && centiBitClock === 1'b0)
				seen++;
			prev = centiBitClock;
			if (seen == n)
				return;
		end
		cmp(16'h0, 16'h1, "centi clock stalled");
	endtask

	task automatic pulseXfr();
		transferPulse <= 1'b1;
		repeat (3) @(posedge ref_clk);
		transferPulse <= 1'b0;
		repeat (4) @(posedge ref_clk);
	endtask

	// loads at chosen counts in both halves of the bit
	task automatic scenTransfer();
		int ks[4] = '{0, 1, 49, 23};
		int v;
		logic [7:0] expDig;
		for (int h = 0; h < 2; h++)
			foreach (ks[i])
			begin
				waitBt(h[0]);
				waitCenti(ks[i] + 1);
				pulseXfr();
				v = h ? 49 - ks[i] : ks[i];
				expDig = {enc(v / 10), enc(v % 10)};
				cmp({distTens, distUnits}, expDig, "digits");
				cmp(addOneFlag, h[0], "add-one flag");
			end
		waitBt(1'b0);
		cmp({distTens, distUnits, addOneFlag}, {enc(2), enc(6), 1'b1}, "held value");
	endtask

	task automatic scenReset();
		rst_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		cmp({distTens, distUnits, addOneFlag}, 16'h0, "reset digits");
		cmp({bitTiming, stopTransfer, centiBitClock}, 16'h0, "reset levels");
		cmp(transitionLines_n, 16'h3ff, "reset lines");
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
	endtask

	// line edges early or late within one measured bit period
	task automatic scenCorrection(input logic late, input int edges);
		int t0;
		int s0;
		logic [15:0] expLen;
		doReset();
		waitBt(1'b1);
		t0 = cyc;
		s0 = spikes;
		if (late)
			waitBt(1'b0);
		repeat (edges)
		begin
			line_source_model_inst.lineFall(10);
			repeat (10) @(posedge ref_clk);
		end
		waitBt(1'b1);
		// an add nets one timebase pulse shorter, a subtract one longer
		if (late)
			expLen = (edges >= 3) ? 16'h31c : 16'h320;
		else
			expLen = (edges >= 4) ? 16'h324 : 16'h320;
		cmp(16'(cyc - t0), expLen, "bit period");
		cmp(16'(spikes - s0), 16'(edges), "edge spikes");
		cmp(16'(starts), 16'h0, "start reset in synchronous mode");
	endtask

	task automatic scenStartStop(input logic five, input int stopLine);
		int s0;
		startStopMode <= 1'b1;
		fiveLevelCode <= five;
		doReset();
		s0 = centiFalls;
		repeat (100) @(posedge ref_clk);
		cmp(16'(centiFalls - s0), 16'h0, "gated before start");
		repeat (2)
		begin
			s0 = starts;
			line_source_model_inst.lineFall(10);
			repeat (10) @(posedge ref_clk);
			cmp(16'(starts - s0), 16'h1, "start reset");
			cmp(stopTransfer, 1'b0, "stop transfer at start");
			cmp(transitionLines_n, 16'h3fe, "line zero at start");
			line_source_model_inst.lineFall(10);
			repeat (10) @(posedge ref_clk);
			cmp(16'(starts - s0), 16'h1, "spike not blocked");
			for (int k = 1; k <= stopLine + 1; k++)
			begin
				waitBt(1'b1);
				repeat (3) @(posedge ref_clk);
				cmp(transitionLines_n, {6'h0, ~(10'h1 << (k % 10))}, "lines");
				cmp(stopTransfer, k <= stopLine, "stop transfer");
			end
			// let the last clock fall before the gate closed be counted first
			repeat (4) @(posedge ref_clk);
			s0 = centiFalls;
			repeat (100) @(posedge ref_clk);
			cmp(16'(centiFalls - s0), 16'h0, "gated in stop");
		end
		startStopMode <= 1'b0;
		@(posedge ref_clk);
	endtask

	initial
	begin
		doReset();
		scenTransfer();
		scenReset();
		scenCorrection(1'b0, 0);
		scenCorrection(1'b0, 3);
		scenCorrection(1'b0, 4);
		scenCorrection(1'b1, 2);
		scenCorrection(1'b1, 4);
		scenStartStop(1'b1, STOP_LINE_5);
		scenStartStop(1'b0, STOP_LINE_8);
		print_verdict();
	end

	initial
	begin
		repeat (90000) @(posedge ref_clk);
		mismatches++;
		print_verdict();
	end
endmodule

`default_nettype wire
